// ### psr_cfg.svh
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// Overview of operation
// - writes to control one only change bits present in capability two
// - writes to the port control only change bits present in capability four
// - control one bit 1 resets serial port one, bit 0 port zero
// - port control bits 0..4 reset io ports a..e; bits 31:5 read zero
// - both reset control registers clear to zero on system reset
// - control one at 0x044, port control at 0x048 above base 0x400FE000

// block base and register offsets
`define PSR_BASE_ADDR 32'h400F_E000
`define PSR_BASE_HI_MSB 31
`define PSR_BASE_HI_LSB 12
`define PSR_OFS_CTRL_ONE 12'h044
`define PSR_OFS_PORT_CTRL 12'h048

// reset values and writable bits
`define PSR_RST_CTRL_ONE 32'h0000_0000
`define PSR_RST_PORT_CTRL 32'h0000_0000
`define PSR_WMASK_CTRL_ONE 32'h0107_0113
`define PSR_WMASK_PORT_CTRL 32'h0000_001F
`define PSR_RDATA_UNMAPPED 32'h0000_0000

// field positions in control one
`define PSR_BIT_SERIAL_ZERO 0
`define PSR_BIT_SERIAL_ONE 1
`define PSR_BIT_SYNC_SERIAL 4
`define PSR_BIT_ENCODER 8
`define PSR_BIT_COUNTER_ZERO 16
`define PSR_BIT_COUNTER_ONE 17
`define PSR_BIT_COUNTER_TWO 18
`define PSR_BIT_ANALOG_CMP 24
`endif

// ### psr_pkg.sv
package psr_pkg;
    // reset request lines to the peripherals, one per unit
    typedef struct packed {
        logic analog_cmp_zero_reset;
        logic gp_counter_two_reset;
        logic gp_counter_one_reset;
        logic gp_counter_zero_reset;
        logic encoder_zero_reset;
        logic sync_serial_zero_reset;
        logic serial_port_one_reset;
        logic serial_port_zero_reset;
    } psr_periph_resets_type;

    typedef struct packed {
        logic io_port_e_reset;
        logic io_port_d_reset;
        logic io_port_c_reset;
        logic io_port_b_reset;
        logic io_port_a_reset;
    } psr_port_resets_type;

    // whole state of the block
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [31:0] peripheral_reset_ctrl_one;
        logic [31:0] port_reset_ctrl;
    } psr_state_type;
endpackage : psr_pkg

// ### psr_top.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "psr_cfg.svh"
module psr_top
    import psr_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [31:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] i_capability_word_two,
    input wire logic [31:0] i_capability_word_four,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output psr_periph_resets_type o_periph_resets,
    output psr_port_resets_type o_port_resets
);

    logic rst_meta_ff;
    logic rst_sync_ff;
    psr_state_type state_ff;
    psr_state_type nxt_state;
    logic [31:0] be_mask;
    logic in_block;
    logic hit_one;
    logic hit_port;
    logic req;
    logic rd_take;
    logic wr_take;
    // decode constants as sized vectors; a bare literal cannot be sliced
    localparam logic [31:0] base_addr = `PSR_BASE_ADDR;
    localparam logic [11:0] ofs_one = `PSR_OFS_CTRL_ONE;
    localparam logic [11:0] ofs_port = `PSR_OFS_PORT_CTRL;
    localparam logic [31:0] wmask_one = `PSR_WMASK_CTRL_ONE;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // byte enables widened to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_be
            assign be_mask[gi*8 +: 8] = {8{i_byteenable[gi]}};
        end
    endgenerate

    // address decode; low two bits ignored, words are aligned
    assign in_block = i_address[`PSR_BASE_HI_MSB:`PSR_BASE_HI_LSB] ==
        base_addr[`PSR_BASE_HI_MSB:`PSR_BASE_HI_LSB];
    assign hit_one = in_block &&
        i_address[11:2] == ofs_one[11:2];
    assign hit_port = in_block &&
        i_address[11:2] == ofs_port[11:2];

    // one wait cycle per access; read data lands on the edge that raises ack, the write on the edge that drops it
    assign req = i_read | i_write;
    assign rd_take = i_read & state_ff.ack;
    assign wr_take = i_write & state_ff.ack;
    assign o_waitrequest = req & ~state_ff.ack;

    // next state: decode, masked writes, read capture
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.ack = req & ~state_ff.ack;
        if (i_read && !state_ff.ack)
        begin
            if (hit_one)
                nxt_state.rdata = state_ff.peripheral_reset_ctrl_one;
            else if (hit_port)
                nxt_state.rdata = state_ff.port_reset_ctrl;
            else
                nxt_state.rdata = `PSR_RDATA_UNMAPPED;
        end
        // absent units keep their bit, so a stray write cannot touch them
        if (wr_take && hit_one)
        begin
            nxt_state.peripheral_reset_ctrl_one =
                (i_writedata & be_mask & i_capability_word_two
                    & `PSR_WMASK_CTRL_ONE) |
                (state_ff.peripheral_reset_ctrl_one &
                    ~(be_mask & i_capability_word_two));
        end
        if (wr_take && hit_port)
        begin
            nxt_state.port_reset_ctrl =
                (i_writedata & be_mask & i_capability_word_four
                    & `PSR_WMASK_PORT_CTRL) |
                (state_ff.port_reset_ctrl &
                    ~(be_mask & i_capability_word_four));
        end
    end

    // state register, cleared to zero by reset
    always_ff @(posedge i_mclk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            state_ff.ack <= 1'b0;
            state_ff.rdata <= 32'h0000_0000;
            state_ff.peripheral_reset_ctrl_one <= `PSR_RST_CTRL_ONE;
            state_ff.port_reset_ctrl <= `PSR_RST_PORT_CTRL;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from flops; a set bit holds its unit in reset
    assign o_readdata = state_ff.rdata;
    assign o_periph_resets.analog_cmp_zero_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_ANALOG_CMP];
    assign o_periph_resets.gp_counter_two_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_COUNTER_TWO];
    assign o_periph_resets.gp_counter_one_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_COUNTER_ONE];
    assign o_periph_resets.gp_counter_zero_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_COUNTER_ZERO];
    assign o_periph_resets.encoder_zero_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_ENCODER];
    assign o_periph_resets.sync_serial_zero_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_SYNC_SERIAL];
    assign o_periph_resets.serial_port_one_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_SERIAL_ONE];
    assign o_periph_resets.serial_port_zero_reset =
        state_ff.peripheral_reset_ctrl_one[`PSR_BIT_SERIAL_ZERO];
    assign o_port_resets = state_ff.port_reset_ctrl[4:0];

    // checks on the register behaviour
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!rst_sync_ff);

    a_one_cap_mask: assert property (
        wr_take && hit_one |=>
        ((state_ff.peripheral_reset_ctrl_one ^
          $past(state_ff.peripheral_reset_ctrl_one)) &
         ~$past(i_capability_word_two)) == 32'h0000_0000)
        else $error("control one changed an absent unit bit");

    a_port_cap_mask: assert property (
        wr_take && hit_port |=>
        ((state_ff.port_reset_ctrl ^ $past(state_ff.port_reset_ctrl)) &
         ~$past(i_capability_word_four)) == 32'h0000_0000)
        else $error("port control changed an absent port bit");

    a_serial_zero_write: assert property (
        wr_take && hit_one && i_capability_word_two[0] && i_byteenable[0]
        |=> o_periph_resets.serial_port_zero_reset == $past(i_writedata[0]))
        else $error("serial port zero reset did not follow write");

    a_port_upper_zero: assert property (
        state_ff.port_reset_ctrl[31:5] == 27'h000_0000)
        else $error("port control reserved bits not zero");

    a_reset_clear: assert property (
        $rose(rst_sync_ff) |->
        state_ff.peripheral_reset_ctrl_one == 32'h0000_0000 &&
        o_port_resets == 5'h00)
        else $error("reset controls not clear after reset");

    a_read_decode: assert property (
        rd_take && hit_port |-> o_readdata == state_ff.port_reset_ctrl)
        else $error("port control read returned wrong data");

    a_unmapped_read: assert property (
        rd_take && !hit_one && !hit_port |-> o_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_hold_without_write: assert property (
        !wr_take |=> $stable(state_ff.peripheral_reset_ctrl_one) &&
        $stable(state_ff.port_reset_ctrl))
        else $error("reset control changed without a write");

    a_single_wait: assert property (
        o_waitrequest |=> !o_waitrequest [*1] ##1 !state_ff.ack)
        else $error("wait request longer than one cycle");

    a_serial_one_write: assert property (
        wr_take && hit_one && i_capability_word_two[1] && i_byteenable[0]
        |=> o_periph_resets.serial_port_one_reset == $past(i_writedata[1]))
        else $error("serial port one reset did not follow write");

    a_port_a_write: assert property (
        wr_take && hit_port && i_capability_word_four[0] && i_byteenable[0]
        |=> o_port_resets.io_port_a_reset == $past(i_writedata[0]))
        else $error("io port a reset did not follow write");

    a_one_upper_zero: assert property (
        (state_ff.peripheral_reset_ctrl_one & ~wmask_one) == 32'h0000_0000)
        else $error("control one reserved bits not zero");

    a_one_read: assert property (
        rd_take && hit_one |->
        o_readdata == state_ff.peripheral_reset_ctrl_one)
        else $error("control one read returned wrong data");

    a_counter_write: assert property (
        wr_take && hit_one && i_byteenable[2] &&
        i_capability_word_two[`PSR_BIT_COUNTER_ZERO] |=>
        o_periph_resets.gp_counter_zero_reset ==
        $past(i_writedata[`PSR_BIT_COUNTER_ZERO]))
        else $error("counter zero reset did not follow write");

    c_write_one: cover property (wr_take && hit_one);
    c_write_port: cover property (wr_take && hit_port);
    c_read_one: cover property (rd_take && hit_one);
    c_unmapped: cover property (req && !hit_one && !hit_port);
    c_read_port: cover property (rd_take && hit_port);
endmodule : psr_top

// ### psr_top_bench.sv
`timescale 1ns/1ns
`include "psr_cfg.svh"
module psr_top_bench import psr_pkg::*;;
    localparam logic [31:0] A1 = `PSR_BASE_ADDR + 32'h0000_0044;
    localparam logic [31:0] A2 = `PSR_BASE_ADDR + 32'h0000_0048;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [31:0] i_address = 32'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'h0;
    logic [31:0] cap2 = 32'h0;
    logic [31:0] cap4 = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    psr_periph_resets_type o_periph_resets;
    psr_port_resets_type o_port_resets;
    logic wr_q = 1'b1;
    logic [31:0] rd_q = 32'h0;
    logic [31:0] rd;
    logic [31:0] tab [5] = '{A1, A2, A1 + 32'h8, A1 - 32'h4, A1 ^ 32'h1000};
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 5972;
    int m1 = 0;
    int m2 = 0;
    psr_top u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .i_capability_word_two(cap2), .i_capability_word_four(cap4),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_periph_resets(o_periph_resets), .o_port_resets(o_port_resets));
    initial forever #5 i_mclk = ~i_mclk;
    // mid-cycle copies, so the edge never races the design's flops
    always @(negedge i_mclk)
    begin
        wr_q = o_waitrequest;
        rd_q = o_readdata;
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until waitrequest seen low at an edge
    task bus_op(input bit w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        @(posedge i_mclk);
        i_read <= !w;
        i_write <= w;
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end while (wr_q !== 1'b0 && n < 20);
        chk("answer within bound", 32'h1, 32'(n < 20));
        rd = rd_q;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus_op
    // model: only mapped, present, writable, enabled bits move
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        int lm;
        bus_op(1'b1, a, d, be); // model after the edge, capabilities settled
        lm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (a == A1)
            lm = lm & `PSR_WMASK_CTRL_ONE & cap2;
        else if (a == A2)
            lm = lm & `PSR_WMASK_PORT_CTRL & cap4;
        else
            lm = 0;
        if (a == A1)
            m1 = (m1 & ~lm) | (d & lm);
        else
            m2 = (m2 & ~lm) | (d & lm);
    endtask : wr
    task chk_all;
        bus_op(1'b0, A1, 32'h0, 4'hF);
        chk("control one", 32'(m1), rd);
        bus_op(1'b0, A2, 32'h0, 4'hF);
        chk("port control", 32'(m2), rd);
        bus_op(1'b0, A1 + 32'h8, 32'h0, 4'hF);
        chk("unmapped", `PSR_RDATA_UNMAPPED, rd);
        @(negedge i_mclk);
        chk("periph lines", {m1[24], m1[18:16], m1[8], m1[4], m1[1:0]},
            32'(o_periph_resets));
        chk("port lines", m2[4:0], 32'(o_port_resets));
        // back on a rising edge, so stimulus never moves on the falling one
        @(posedge i_mclk);
    endtask : chk_all
    task do_reset;
        i_resetn <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        m1 = 0;
        m2 = 0;
        chk_all();
        $display("test reset done");
    endtask : do_reset
    initial
    begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        do_reset();
        // all present: every writable bit set, reserved stay zero
        cap2 <= 32'hFFFF_FFFF;
        cap4 <= 32'hFFFF_FFFF;
        wr(A1, 32'hFFFF_FFFF, 4'hF);
        wr(A2, 32'hFFFF_FFFF, 4'hF);
        chk_all();
        // nothing present: clearing write must not land
        cap2 <= 32'h0;
        cap4 <= 32'h0;
        wr(A1, 32'h0, 4'hF);
        wr(A2, 32'h0, 4'hF);
        chk_all();
        // read-modify-write: reserved bits go back exactly as read
        cap2 <= 32'hFFFF_FFFF;
        bus_op(1'b0, A1, 32'h0, 4'hF);
        wr(A1, rd & ~(32'h1 << `PSR_BIT_ENCODER), 4'hF);
        chk_all();
        $display("test directed done");
        // random masks, lanes, data and addresses
        repeat (80)
        begin
            cap2 <= $random(seed);
            cap4 <= $random(seed);
            wr(tab[{$random(seed)} % 5], $random(seed),
                4'($random(seed)));
            chk_all();
        end
        $display("test random done");
        do_reset();
        stop_test();
    end
endmodule : psr_top_bench
